// File: rtl/ccd_pkg.sv
// Package for the CPU clock select and divider block.
// Assumes a 20 MHz system clock that stands for the running oscillator.
package ccd_pkg;

	// ************************************************************
	// Register map on the Wishbone bus (byte addresses)
	// ************************************************************
	localparam logic [7:0] CCD_REG_DIVIDER = 8'h00;
	localparam logic [7:0] CCD_REG_PORT2_MODE = 8'h04;
	localparam logic [7:0] CCD_REG_STATUS = 8'h08;
	localparam int CCD_CLKOUT_EN_BIT = 0;
	localparam int CCD_ST_MODE_LSB = 0;
	localparam int CCD_ST_LEGACY_BIT = 3;
	localparam int CCD_ST_RUN_BIT = 4;
	localparam int CCD_ST_DIV_LSB = 8;
	localparam logic [7:0] CCD_DIVIDER_RESET = 8'h00;

	// ************************************************************
	// Timing constants
	// ************************************************************
	localparam logic [2:0] CCD_MC_CLKS = 3'h6;
	localparam logic [2:0] CCD_CLKOUT_HALF = 3'h3;
	localparam logic [10:0] CCD_START_XTAL_CLKS = 11'h400;
	localparam logic [10:0] CCD_START_RC_CLKS = 11'h100;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		CCD_OSC_LOW_XTAL = 3'h0,
		CCD_OSC_MED_XTAL = 3'h1,
		CCD_OSC_HIGH_XTAL = 3'h2,
		CCD_OSC_RC = 3'h3,
		CCD_OSC_EXT_CLK = 3'h4
	} ccd_osc_mode_type;

	typedef enum logic [2:0] {
		CCD_ST_WARMUP = 3'b001,
		CCD_ST_RUN = 3'b010,
		CCD_ST_STOPPED = 3'b100
	} ccd_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} ccd_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ccd_wb_rsp_type;

endpackage : ccd_pkg

// File: rtl/ccd_clock_ctrl.sv
// CPU clock source selection, legacy halving, programmable divider and clock output.
// Assumes SYS_CLK is the running oscillator; configuration straps come from fuses.
//
// Functional notes
// - Medium crystal mode, 100 kHz to 4 MHz, selected by configuration straps.
// - High crystal mode, 4 MHz to 20 MHz, selected by configuration straps.
// - RC mode nominal 6 MHz; its CPU clock passes through the divider.
// - External clock mode releases the oscillator output pin to the port.
// - Clock output only in RC or external clock modes, never with crystals.
// - With enable set, clock output runs whenever the oscillator runs, Idle too.
// - Clock output frequency is one sixth of the CPU clock.
// - Legacy timing bit halves the CPU clock.
// - Six CPU clocks per machine cycle; twelve oscillator clocks when legacy.
// - Legacy halving applies to peripheral timing as well.
// - Legacy bit is a nonvolatile configuration strap, not software writable.
// - Divider value zero (reset default) gives undivided or halved rate.
// - Divider value N from 1 to 255 divides by 2 times (N plus 1).
// - Divider writes accepted any time without disturbing execution.
// - After Power Down wait 1024 CPU clocks for crystals, else 256.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module ccd_clock_ctrl #(
	parameter int DIV_WIDTH = 8
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Configuration straps from the nonvolatile user configuration
	input wire ccd_pkg::ccd_osc_mode_type OSC_MODE_CFG,
	input wire logic LEGACY_TIMING_CFG,
	// Power control from the core
	input wire logic POWER_DOWN,
	// Wishbone slave
	input wire ccd_pkg::ccd_wb_req_type WB_REQ,
	output ccd_pkg::ccd_wb_rsp_type WB_RSP,
	// Port function of the oscillator output pin
	input wire logic PORT_PIN_O,
	input wire logic PORT_PIN_OE,
	// Oscillator output pin
	output logic OSC_OUT_O,
	output logic OSC_OUT_OE,
	output logic OSC_OUT_PORT_FREE,
	// Clock enables towards core and peripherals
	output logic CPU_CLK_EN,
	output logic MACHINE_CYCLE_EN,
	output logic CPU_RUN
);
	import ccd_pkg::*;

	generate
		if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_bad_width
			$error("DIV_WIDTH must lie between 1 and 8");
		end
	endgenerate

	// ************************************************************
	// Configuration straps
	// ************************************************************
	// Straps pass two flip-flops and are loaded only while reset is held, so
	// nothing software does can alter the oscillator mode or legacy timing.
	ccd_osc_mode_type mode_sync1_reg, mode_sync2_reg, mode_reg, mode_next;
	logic legacy_sync1_reg, legacy_sync2_reg, legacy_reg, legacy_next;

	always_comb begin
		mode_next = mode_reg;
		legacy_next = legacy_reg;
		if (SYS_RST) begin
			mode_next = mode_sync2_reg;
			legacy_next = legacy_sync2_reg;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		mode_sync1_reg <= OSC_MODE_CFG;
		mode_sync2_reg <= mode_sync1_reg;
		legacy_sync1_reg <= LEGACY_TIMING_CFG;
		legacy_sync2_reg <= legacy_sync1_reg;
		mode_reg <= mode_next;
		legacy_reg <= legacy_next;
	end

	logic is_crystal;
	logic clk_out_mode;
	assign is_crystal = (mode_reg != CCD_OSC_RC) && (mode_reg != CCD_OSC_EXT_CLK);
	assign clk_out_mode = !is_crystal;

	// ************************************************************
	// Software registers
	// ************************************************************
	logic [DIV_WIDTH-1:0] div_val_reg, div_val_next;
	logic clkout_en_reg, clkout_en_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [DIV_WIDTH-1:0] div_act_reg;
	ccd_state_type state_reg;
	logic bus_req;
	logic bus_wr;

	assign bus_req = WB_REQ.cyc && WB_REQ.stb && !ack_reg;
	assign bus_wr = bus_req && WB_REQ.we && WB_REQ.sel[0];

	always_comb begin
		div_val_next = div_val_reg;
		clkout_en_next = clkout_en_reg;
		ack_next = bus_req;
		rdata_next = 32'h0000_0000;
		if (WB_REQ.adr == CCD_REG_DIVIDER) begin
			if (bus_wr) begin
				div_val_next = WB_REQ.dat[DIV_WIDTH-1:0];
			end
			rdata_next[DIV_WIDTH-1:0] = div_val_reg;
		end else if (WB_REQ.adr == CCD_REG_PORT2_MODE) begin
			if (bus_wr) begin
				clkout_en_next = WB_REQ.dat[CCD_CLKOUT_EN_BIT];
			end
			rdata_next[CCD_CLKOUT_EN_BIT] = clkout_en_reg;
		end else if (WB_REQ.adr == CCD_REG_STATUS) begin
			rdata_next[CCD_ST_MODE_LSB +: 3] = mode_reg;
			rdata_next[CCD_ST_LEGACY_BIT] = legacy_reg;
			rdata_next[CCD_ST_RUN_BIT] = (state_reg == CCD_ST_RUN);
			rdata_next[CCD_ST_DIV_LSB +: DIV_WIDTH] = div_act_reg;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			div_val_reg <= CCD_DIVIDER_RESET[DIV_WIDTH-1:0];
			clkout_en_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			div_val_reg <= div_val_next;
			clkout_en_reg <= clkout_en_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign WB_RSP.ack = ack_reg;
	assign WB_RSP.dat = rdata_reg;

	// ************************************************************
	// Legacy halving and programmable divider
	// ************************************************************
	// A new ratio is loaded only when the divided clock wraps; switching in
	// mid-count would give one short CPU clock that could break timing.
	logic osc_run;
	logic pre_tog_reg, pre_tog_next;
	logic pre_en;
	logic [DIV_WIDTH:0] div_cnt_reg, div_cnt_next;
	logic [DIV_WIDTH-1:0] div_act_next;
	logic [DIV_WIDTH:0] div_term;
	logic cpu_en;

	assign osc_run = (state_reg != CCD_ST_STOPPED);
	assign pre_en = osc_run && (!legacy_reg || pre_tog_reg);
	assign div_term = {div_act_reg, 1'b1};
	assign cpu_en = pre_en && ((div_act_reg == '0) || (div_cnt_reg == div_term));

	always_comb begin
		pre_tog_next = pre_tog_reg;
		div_cnt_next = div_cnt_reg;
		div_act_next = div_act_reg;
		if (osc_run) begin
			pre_tog_next = !pre_tog_reg;
		end
		if (cpu_en) begin
			div_cnt_next = '0;
			div_act_next = div_val_reg;
		end else if (pre_en) begin
			div_cnt_next = div_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			pre_tog_reg <= 1'b0;
			div_cnt_reg <= '0;
			div_act_reg <= '0;
		end else begin
			pre_tog_reg <= pre_tog_next;
			div_cnt_reg <= div_cnt_next;
			div_act_reg <= div_act_next;
		end
	end

	// ************************************************************
	// Oscillator start-up after Power Down
	// ************************************************************
	ccd_state_type state_next;
	logic [10:0] start_cnt_reg, start_cnt_next;
	logic [10:0] start_target;

	assign start_target = is_crystal ? CCD_START_XTAL_CLKS : CCD_START_RC_CLKS;

	always_comb begin
		state_next = state_reg;
		start_cnt_next = start_cnt_reg;
		case (state_reg)
			CCD_ST_WARMUP: begin
				if (cpu_en) begin
					start_cnt_next = start_cnt_reg + 11'h001;
					if (start_cnt_reg == start_target - 11'h001) begin
						state_next = CCD_ST_RUN;
					end
				end
			end
			CCD_ST_RUN: begin
				if (POWER_DOWN) begin
					state_next = CCD_ST_STOPPED;
				end
			end
			CCD_ST_STOPPED: begin
				start_cnt_next = '0;
				if (!POWER_DOWN) begin
					state_next = CCD_ST_WARMUP;
				end
			end
			default: begin
				state_next = CCD_ST_WARMUP;
				start_cnt_next = '0;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_reg <= CCD_ST_WARMUP;
			start_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			start_cnt_reg <= start_cnt_next;
		end
	end

	// ************************************************************
	// Machine cycle and clock output
	// ************************************************************
	// The six-clock counter runs whenever the oscillator runs, so the clock
	// output keeps going in Idle; software stops it through the enable bit.
	logic [2:0] mc_cnt_reg, mc_cnt_next;
	logic clkout_reg, clkout_next;
	logic clk_out_active;

	always_comb begin
		mc_cnt_next = mc_cnt_reg;
		clkout_next = clkout_reg;
		if (cpu_en) begin
			if (mc_cnt_reg == CCD_MC_CLKS - 3'h1) begin
				mc_cnt_next = '0;
			end else begin
				mc_cnt_next = mc_cnt_reg + 3'h1;
			end
			if (mc_cnt_reg == CCD_CLKOUT_HALF - 3'h1 || mc_cnt_reg == CCD_MC_CLKS - 3'h1) begin
				clkout_next = !clkout_reg;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			mc_cnt_reg <= '0;
			clkout_reg <= 1'b0;
		end else begin
			mc_cnt_reg <= mc_cnt_next;
			clkout_reg <= clkout_next;
		end
	end

	assign clk_out_active = clkout_en_reg && clk_out_mode && osc_run;
	assign OSC_OUT_PORT_FREE = (mode_reg == CCD_OSC_EXT_CLK);
	assign OSC_OUT_O = clk_out_active ? clkout_reg : (OSC_OUT_PORT_FREE && PORT_PIN_O);
	assign OSC_OUT_OE = clk_out_active || (OSC_OUT_PORT_FREE && PORT_PIN_OE);
	assign CPU_RUN = (state_reg == CCD_ST_RUN);
	assign CPU_CLK_EN = cpu_en && CPU_RUN;
	assign MACHINE_CYCLE_EN = cpu_en && CPU_RUN && (mc_cnt_reg == CCD_MC_CLKS - 3'h1);

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence pd_entered_s;
		state_reg == CCD_ST_RUN ##1 state_reg == CCD_ST_STOPPED;
	endsequence
	sequence pd_left_s;
		state_reg == CCD_ST_STOPPED ##1 state_reg == CCD_ST_WARMUP;
	endsequence

	div_zero_rate_a: assert property ((div_act_reg == '0) && !legacy_reg && osc_run |-> cpu_en)
		else $error("undivided rate lost a CPU clock");
	legacy_half_a: assert property (legacy_reg && (div_act_reg == '0) && cpu_en |=> !cpu_en)
		else $error("legacy timing did not halve the clock");
	div_count_a: assert property (pre_en && !cpu_en
		|=> div_cnt_reg == (DIV_WIDTH+1)'($past(div_cnt_reg) + 1'b1))
		else $error("divider count skipped");
	div_switch_a: assert property ($changed(div_act_reg) |-> $past(cpu_en))
		else $error("divider ratio changed off a boundary");
	clkout_edge_a: assert property ($changed(clkout_reg) |-> $past(cpu_en)
		&& ($past(mc_cnt_reg) == CCD_CLKOUT_HALF - 3'h1 || $past(mc_cnt_reg) == CCD_MC_CLKS - 3'h1))
		else $error("clock output edge at wrong CPU clock");
	clkout_mode_a: assert property (clkout_en_reg && clk_out_mode && osc_run
		|-> OSC_OUT_OE && OSC_OUT_O == clkout_reg)
		else $error("clock output not driven");
	clkout_xtal_a: assert property (is_crystal |-> !OSC_OUT_OE)
		else $error("oscillator output pin driven in crystal mode");
	pin_release_a: assert property ((mode_reg == CCD_OSC_EXT_CLK) && !clkout_en_reg
		|-> OSC_OUT_OE == PORT_PIN_OE)
		else $error("oscillator output pin not released");
	machine_cycle_a: assert property (MACHINE_CYCLE_EN |=> !MACHINE_CYCLE_EN [*5])
		else $error("machine cycle shorter than six CPU clocks");
	legacy_fixed_a: assert property ($stable(legacy_reg) && $stable(mode_reg))
		else $error("configuration straps changed outside reset");
	pd_stop_a: assert property (pd_entered_s |-> !CPU_CLK_EN)
		else $error("CPU clock ran in Power Down");
	warmup_len_a: assert property (pd_left_s ##1 (!CPU_RUN) [*8] |-> start_cnt_reg < start_target)
		else $error("start-up count out of range");
	run_release_a: assert property ($rose(CPU_RUN) |-> $past(start_cnt_reg) == start_target - 11'h001)
		else $error("execution resumed before oscillator settled");
	bus_ack_a: assert property (bus_req |=> ack_reg ##1 !ack_reg)
		else $error("bus acknowledge not one cycle");

endmodule : ccd_clock_ctrl

// File: tb/ccd_pin_partner.sv
// Port-side model of the oscillator output pin: port logic plus a pull-up on the wire.
// Assumes it shares the block's clock and reset.
`timescale 1ns/100ps
module ccd_pin_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Port drive and pin
	output logic port_o,
	output logic port_oe,
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic pin_level
);
	// The drive value changes every cycle so that a stale value is never taken for a match.
	always_ff @(posedge clk) begin
		if (rst) begin
			port_o <= 1'b0;
			port_oe <= 1'b0;
		end else begin
			port_o <= ~port_o;
			port_oe <= 1'b1;
		end
	end
	// The wire has a pull-up, so a released pin reads high.
	assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule : ccd_pin_partner

// File: tb/cpu_clock_select_divider_tb_top.sv
// Testbench for the CPU clock select and divider block.
// Assumes the pin partner model and the package are compiled first.
`timescale 1ns/100ps
module cpu_clock_select_divider_tb_top;
	import ccd_pkg::*;
	logic SYS_CLK, SYS_RST, leg, pd, port_o, port_oe, pin_level;
	logic out_o, out_oe, free, cpu_en, mc_en, run;
	ccd_osc_mode_type mode;
	ccd_wb_req_type req;
	ccd_wb_rsp_type rsp;
	logic [31:0] q;
	int err_total, n_compared, p;
	ccd_clock_ctrl i_ccd_clock_ctrl (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .OSC_MODE_CFG(mode),
		.LEGACY_TIMING_CFG(leg), .POWER_DOWN(pd), .WB_REQ(req), .WB_RSP(rsp), .PORT_PIN_O(port_o),
		.PORT_PIN_OE(port_oe), .OSC_OUT_O(out_o), .OSC_OUT_OE(out_oe), .OSC_OUT_PORT_FREE(free),
		.CPU_CLK_EN(cpu_en), .MACHINE_CYCLE_EN(mc_en), .CPU_RUN(run));
	ccd_pin_partner i_ccd_pin_partner (.clk(SYS_CLK), .rst(SYS_RST), .port_o(port_o),
		.port_oe(port_oe), .pin_o(out_o), .pin_oe(out_oe), .pin_level(pin_level));
	// ************************************************************
	// Clock and shared tasks
	// ************************************************************
	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end
	task automatic complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
		int n;
		n = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d, sel: s};
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (rsp.ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk("bus ack", 1, 0);
			complete_run;
		end
		q = rsp.dat;
		req <= '0;
		@(posedge SYS_CLK);
	endtask : wb
	task automatic wait_run(input int e);
		int n;
		n = 0;
		while (run !== 1'b1 && n < 4000) begin
			@(posedge SYS_CLK);
			n++;
		end
		chk("warmup", 1, 32'(n >= e && n <= e + 16));
		if (n >= 4000) begin
			complete_run;
		end
	endtask : wait_run
	// Selector 0 times the gap between CPU pulses, 1 between machine cycle pulses, 2 between rising edges of the clock output.
	task automatic period(input int s, output int pr);
		logic prv, cur;
		int n, k;
		prv = 1'b1;
		n = 0;
		k = 0;
		pr = 0;
		while (k < 2 && n < 8000) begin
			@(posedge SYS_CLK);
			cur = s == 0 ? cpu_en : s == 1 ? mc_en : out_o;
			n++;
			if (cur === 1'b1 && prv !== 1'b1) begin
				pr = n;
				k++;
				n = 0;
			end
			prv = s == 2 ? cur : 1'b0;
		end
		if (k < 2) begin
			chk("pulse seen", 1, 0);
			complete_run;
		end
	endtask : period
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic boot(input int m, input logic l);
		SYS_RST <= 1'b1;
		mode <= ccd_osc_mode_type'(m);
		leg <= l;
		pd <= 1'b0;
		repeat (5) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		wait_run((m >= 3 ? 256 : 1024) * (l ? 2 : 1));
		wb(0, CCD_REG_STATUS, 0);
		chk("status", {27'h0, 1'b1, l, 3'(m)}, q & 32'h0000_FF1F);
		chk("port free", 32'(m == 4), free);
		$display("boot mode %0d done", m);
	endtask : boot
	task automatic t_regs;
		wb(0, CCD_REG_DIVIDER, 0);
		chk("divider reset", CCD_DIVIDER_RESET, q);
		wb(0, CCD_REG_PORT2_MODE, 0);
		chk("mode reset", 0, q);
		wb(1, CCD_REG_DIVIDER, 32'h0000_0055, 4'h0);
		wb(0, CCD_REG_DIVIDER, 0);
		chk("masked write", CCD_DIVIDER_RESET, q);
		wb(1, 8'h0C, 32'h0000_00FF);
		wb(0, 8'h0C, 0);
		chk("unmapped", 0, q);
		$display("registers done");
	endtask : t_regs
	task automatic t_div(input logic [7:0] nv, input logic l);
		int e;
		e = (l ? 2 : 1) * (nv == 0 ? 1 : 2 * (nv + 1));
		wb(1, CCD_REG_DIVIDER, {24'h0, nv});
		chk("run kept", 1, run);
		period(0, p);
		chk("cpu period", e, p);
		period(1, p);
		chk("cycle period", 6 * e, p);
		wb(0, CCD_REG_DIVIDER, 0);
		chk("divider", nv, q);
		$display("divider %0d done", nv);
	endtask : t_div
	task automatic t_clkout(input logic drv, input int cpu);
		wb(1, CCD_REG_PORT2_MODE, 1);
		chk("out enable", drv, out_oe);
		if (drv) begin
			period(2, p);
			chk("out period", 6 * cpu, p);
		end
		wb(1, CCD_REG_PORT2_MODE, 0);
		wb(0, CCD_REG_PORT2_MODE, 0);
		chk("enable bit", 0, q);
		$display("clock out done");
	endtask : t_clkout
	task automatic t_pd;
		int n;
		pd <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		n = 0;
		repeat (20) begin
			@(posedge SYS_CLK);
			if (cpu_en !== 1'b0) begin
				n++;
			end
		end
		chk("stopped pulses", 0, n);
		chk("stopped run", 0, run);
		pd <= 1'b0;
		wait_run(256);
		$display("power down done");
	endtask : t_pd
	task automatic t_ext;
		chk("port free", 1, free);
		chk("pin owner", port_oe, out_oe);
		chk("pin level", port_o, pin_level);
		$display("port pin done");
	endtask : t_ext
	initial begin
		SYS_RST = 1'b1;
		mode = CCD_OSC_RC;
		leg = 1'b0;
		pd = 1'b0;
		req = '0;
		err_total = 0;
		n_compared = 0;
		boot(3, 0);
		t_regs;
		t_div(1, 0);
		t_div(255, 0);
		t_div(0, 0);
		t_clkout(1, 1);
		t_pd;
		boot(4, 0);
		t_ext;
		t_clkout(1, 1);
		t_ext;
		boot(2, 1);
		t_div(1, 1);
		t_div(0, 1);
		t_clkout(0, 2);
		wb(1, CCD_REG_STATUS, 0);
		wb(0, CCD_REG_STATUS, 0);
		chk("legacy kept", 1, q[3]);
		boot(0, 0);
		boot(1, 0);
		complete_run;
	end
endmodule : cpu_clock_select_divider_tb_top
